// File: rtl/rco_dev_end.sv
// Device end: serial configuration port, configuration bytes and divided clock output.
// Assumes the serial pins and the switch pad come from another party and are unsynchronised.
`timescale 1ns/1ps
module rco_dev_end (
   input  wire logic           clk,
   input  wire logic           rstn,
   rco_link_if.dev_end         link,
   output logic                extOscSel,
   output logic [3:0]          oscResistor,
   output logic                overtoneMode,
   output logic                sleepMode,
   output logic                cfgSet,
   output logic [1:0]          runMode,
   output logic                powerUpClk
);
   import rco_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: bit 0 clock, 1 data, 2 enable (low), 3 switch pad
   logic [3:0] syncA;
   logic [3:0] syncB;
   logic [3:0] syncC;
   logic [3:0] lvl;
   logic [3:0] lvlPrev;
   logic       sclkRise;
   logic       enRise;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         syncA   <= PIN_IDLE;
         syncB   <= PIN_IDLE;
         syncC   <= PIN_IDLE;
         lvl     <= PIN_IDLE;
         lvlPrev <= PIN_IDLE;
      end else begin
         syncA   <= {link.cfgSwitchPad, link.serEnN, link.serData, link.serClk};
         syncB   <= syncA;
         syncC   <= syncB;
         // Level moves only where the second and third stages agree
         lvl     <= (syncB & ~(syncB ^ syncC)) | (lvl & (syncB ^ syncC));
         lvlPrev <= lvl;
      end
   end

   assign sclkRise = lvl[0] & ~lvlPrev[0] & ~lvl[2];
   assign enRise   = lvl[2] & ~lvlPrev[2];

   ////////////////////////////////////////////////////////////////////////////
   // Serial word assembly
   logic [WORD_W-1:0] shiftReg;
   logic [3:0]        bitCnt;
   logic [WORD_W-1:0] fullWord;
   logic              wordDone;
   logic [4:0]        wrAddr;
   logic [7:0]        wrData;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         shiftReg <= '0;
         bitCnt   <= 4'h0;
      end else if (lvl[2]) begin
         bitCnt <= 4'h0;
      end else if (sclkRise) begin
         shiftReg <= fullWord;
         bitCnt   <= wordDone ? 4'h0 : 4'(bitCnt + 4'h1);
      end
   end

   assign fullWord = {shiftReg[WORD_W-2:0], lvl[1]};
   assign wordDone = sclkRise & (bitCnt == 4'(WORD_W - 1));
   assign wrAddr   = fullWord[WORD_W-1:DATA_W];
   assign wrData   = fullWord[DATA_W-1:0];

   ////////////////////////////////////////////////////////////////////////////
   // Shadow bytes take serial writes; active bytes steer the hardware
   logic [7:0] shadowMem [NUM_REGS];
   logic [7:0] activeMem [NUM_REGS];

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            shadowMem[i] <= REG_RESET;
         end
      end else if (wordDone) begin
         shadowMem[wrAddr] <= wrData;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            activeMem[i] <= REG_RESET;
         end
      end else if (enRise) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            activeMem[i] <= shadowMem[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // First-sequence tracking
   logic firstDone;
   logic rtWritten;
   logic rtValid;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         firstDone <= 1'b0;
         rtWritten <= 1'b0;
         rtValid   <= 1'b0;
      end else begin
         if (enRise) begin
            firstDone <= 1'b1;
            rtWritten <= 1'b0;
            // Clock stays off until a sequence has carried realtime bytes
            if (rtWritten) begin
               rtValid <= 1'b1;
            end
         end else if (wordDone && wrAddr <= RT_LAST) begin
            rtWritten <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decoded configuration
   logic [7:0] rt0;
   logic [7:0] adClk;
   logic       nextCfgSet;
   logic [1:0] nextMode;
   logic       runReq;

   assign rt0          = activeMem[RT_FIRST];
   assign adClk        = activeMem[AD_CLK];
   assign extOscSel    = rt0[RT_EXT_OSC];
   assign oscResistor  = adClk[AD_RES_LSB +: 4];
   // Any non-zero resistor code leaves fundamental operation
   assign overtoneMode = |adClk[AD_RES_LSB +: 4];
   assign powerUpClk   = ~firstDone;

   // Either source can flip the set on its own
   assign nextCfgSet = rt0[RT_SER_SET] ^ lvl[3];
   assign nextMode   = nextCfgSet ? rt0[RT_MODE2_LSB +: 2] : rt0[RT_MODE1_LSB +: 2];

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfgSet    <= 1'b0;
         runMode   <= RCO_SLEEP;
         sleepMode <= 1'b1;
      end else begin
         cfgSet    <= nextCfgSet;
         runMode   <= nextMode;
         sleepMode <= (nextMode == RCO_SLEEP);
      end
   end

   // Power-up clock ignores enable and sleep until the first commit
   assign runReq = powerUpClk |
                   (rtValid & rt0[RT_CLK_EN] & ~sleepMode);

   ////////////////////////////////////////////////////////////////////////////
   // Clock divider; ratio and run state change only at the wrap point,
   // where every tap has just ended a high phase, so no runt pulse appears
   logic [DIV_CNT_W-1:0] divCnt;
   logic [1:0]           divSel;
   logic                 runOn;
   logic [2:0]           tap;
   logic                 clkOutQ;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         divCnt <= '0;
         divSel <= DIV_POWERUP;
         runOn  <= 1'b1;
      end else begin
         divCnt <= DIV_CNT_W'(divCnt + 1'b1);
         if (&divCnt) begin
            divSel <= powerUpClk ? DIV_POWERUP : adClk[AD_DIV_LSB +: 2];
            runOn  <= runReq;
         end
      end
   end

   assign tap = 3'h4 - {1'b0, divSel};

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         clkOutQ <= 1'b0;
      end else begin
         clkOutQ <= runOn & divCnt[tap];
      end
   end

   assign link.clockOut = clkOutQ;

endmodule

// File: rtl/rco_host_end.sv
// Controller end: APB registers turned into serial writes, plus the switch pad.
// Assumes the clock output pin is unsynchronised; APB on the local clock.
`timescale 1ns/1ps
module rco_host_end #(
   parameter int SCLK_HALF = rco_pkg::SCLK_HALF_CYC
) (
   input  wire logic           clk,
   input  wire logic           rstn,
   input  wire logic [7:0]     paddr,
   input  wire logic           psel,
   input  wire logic           penable,
   input  wire logic           pwrite,
   input  wire logic [31:0]    pwdata,
   output logic [31:0]         prdata,
   output logic                pready,
   output logic                pslverr,
   rco_link_if.host_end        link
);
   import rco_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Clock output observation
   logic [2:0] clkSync;
   logic       clkLvl;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         clkSync <= 3'h0;
         clkLvl  <= 1'b0;
      end else begin
         clkSync <= {clkSync[1:0], link.clockOut};
         if (clkSync[1] == clkSync[2]) begin
            clkLvl <= clkSync[2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave, zero wait states
   rco_host_st_t state;
   logic         cmdOk;
   logic         mapped;
   logic         acc;
   logic         wrCmd;
   logic [31:0]  lastCmd;
   logic         padReg;

   assign acc     = psel & penable;
   assign mapped  = (paddr == OFS_CMD) | (paddr == OFS_STAT) | (paddr == OFS_PAD);
   assign cmdOk   = (state == RCO_H_IDLE) | (state == RCO_H_HOLD);
   assign wrCmd   = acc & pwrite & (paddr == OFS_CMD) & cmdOk;
   assign pready  = 1'b1;
   // Busy command writes are refused rather than queued
   assign pslverr = acc & (~mapped | (pwrite & (paddr == OFS_STAT)) |
                           (pwrite & (paddr == OFS_CMD) & ~cmdOk));

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= 32'h0000_0000;
         unique case (paddr)
            OFS_CMD:  prdata <= lastCmd;
            OFS_STAT: prdata <= {29'h0, clkLvl, state == RCO_H_HOLD,
                                 (state == RCO_H_SHIFT) | (state == RCO_H_END)};
            OFS_PAD:  prdata <= {31'h0, padReg};
            default:  prdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lastCmd <= 32'h0000_0000;
         padReg  <= 1'b0;
      end else begin
         if (wrCmd) begin
            lastCmd <= pwdata;
         end
         if (acc && pwrite && paddr == OFS_PAD) begin
            padReg <= pwdata[0];
         end
      end
   end

   assign link.cfgSwitchPad = padReg;

   ////////////////////////////////////////////////////////////////////////////
   // Serial sequencer: data changes with clock low, device samples on rise
   logic [WORD_W-1:0] txWord;
   logic [3:0]        bitIdx;
   logic [7:0]        halfCnt;
   logic              holdOpen;
   logic              sclk;
   logic              enN;
   logic              halfDone;

   assign halfDone = (halfCnt == 8'(SCLK_HALF - 1));

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state    <= RCO_H_IDLE;
         txWord   <= '0;
         bitIdx   <= 4'h0;
         halfCnt  <= 8'h00;
         holdOpen <= 1'b0;
         sclk     <= 1'b0;
         enN      <= 1'b1;
      end else begin
         halfCnt <= halfDone ? 8'h00 : 8'(halfCnt + 8'h01);
         unique case (state)
            RCO_H_IDLE, RCO_H_HOLD: begin
               if (wrCmd) begin
                  // Commands may chain under one low enable
                  txWord   <= {pwdata[CMD_ADDR_LSB +: ADDR_W], pwdata[CMD_DATA_LSB +: DATA_W]};
                  holdOpen <= pwdata[CMD_HOLD];
                  bitIdx   <= 4'(WORD_W - 1);
                  halfCnt  <= 8'h00;
                  sclk     <= 1'b0;
                  enN      <= 1'b0;
                  state    <= RCO_H_SHIFT;
               end
            end
            RCO_H_SHIFT: begin
               if (halfDone) begin
                  if (!sclk) begin
                     sclk <= 1'b1;
                  end else begin
                     sclk <= 1'b0;
                     if (bitIdx == 4'h0) begin
                        enN   <= ~holdOpen;
                        state <= holdOpen ? RCO_H_HOLD : RCO_H_END;
                     end else begin
                        bitIdx <= 4'(bitIdx - 4'h1);
                     end
                  end
               end
            end
            RCO_H_END: begin
               if (halfDone) begin
                  state <= RCO_H_IDLE;
               end
            end
         endcase
      end
   end

   assign link.serClk  = sclk;
   assign link.serData = txWord[bitIdx];
   assign link.serEnN  = enN;

endmodule

// File: rtl/rco_link_if.sv
// Pins between the controller and the clock output block.
// Assumes both ends share one clock; every pin is one-way.
`timescale 1ns/1ps
interface rco_link_if;
   logic serClk;
   logic serData;
   logic serEnN;
   logic cfgSwitchPad;
   logic clockOut;

   modport dev_end (
      input  serClk,
      input  serData,
      input  serEnN,
      input  cfgSwitchPad,
      output clockOut
   );

   modport host_end (
      output serClk,
      output serData,
      output serEnN,
      input  clockOut,
      output cfgSwitchPad
   );
endinterface

// File: rtl/rco_pkg.sv
// Shared constants for the reference clock output block and its controller.
// Assumes a single 250 MHz clock that also serves as the reference in simulation.
package rco_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Serial word: 5-bit address then 8-bit data, MSB first
   localparam int          ADDR_W    = 5;
   localparam int          DATA_W    = 8;
   localparam int          WORD_W    = ADDR_W + DATA_W;
   localparam int          NUM_REGS  = 32;
   localparam logic [7:0]  REG_RESET = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Configuration group bounds and field positions
   localparam logic [4:0]  RT_FIRST      = 5'h00;
   localparam logic [4:0]  RT_LAST       = 5'h03;
   localparam logic [4:0]  AD_CLK        = 5'h08;
   localparam int          RT_EXT_OSC    = 0;
   localparam int          RT_CLK_EN     = 1;
   localparam int          RT_SER_SET    = 2;
   localparam int          RT_MODE2_LSB  = 4;
   localparam int          RT_MODE1_LSB  = 6;
   localparam int          AD_RES_LSB    = 0;
   localparam int          AD_DIV_LSB    = 4;

   typedef enum logic [1:0] {
      RCO_SLEEP   = 2'b00,
      RCO_STANDBY = 2'b01,
      RCO_RX      = 2'b10,
      RCO_TX      = 2'b11
   } rco_mode_t;

   // Divider codes: 00 /32, 01 /16, 10 /8, 11 /4
   localparam logic [1:0]  DIV_POWERUP = 2'b00;
   localparam int          DIV_CNT_W   = 5;
   localparam logic [3:0]  PIN_IDLE    = 4'h4;

   ////////////////////////////////////////////////////////////////////////////
   // Controller register map (APB, byte addresses)
   localparam logic [7:0]  OFS_CMD      = 8'h00;
   localparam logic [7:0]  OFS_STAT     = 8'h04;
   localparam logic [7:0]  OFS_PAD      = 8'h08;
   localparam int          CMD_DATA_LSB = 0;
   localparam int          CMD_ADDR_LSB = 8;
   localparam int          CMD_HOLD     = 16;
   localparam int          STAT_BUSY    = 0;
   localparam int          STAT_OPEN    = 1;
   localparam int          STAT_CLK     = 2;

   typedef enum logic [1:0] {
      RCO_H_IDLE  = 2'b00,
      RCO_H_SHIFT = 2'b01,
      RCO_H_HOLD  = 2'b10,
      RCO_H_END   = 2'b11
   } rco_host_st_t;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int          CLK_PERIOD_PS = 4000;
   localparam int          SCLK_HALF_NS  = 16;
   localparam int          SCLK_HALF_CYC = (SCLK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage

// File: sim/rco_properties.sv
// Checker for the serial link and the divided clock pin between the two ends.
// Assumes SCLK_HALF of 4 cycles and one clock domain shared by both ends.
`timescale 1ns/1ps
module rco_properties (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic serClk,
   input  wire logic serData,
   input  wire logic serEnN,
   input  wire logic cfgSwitchPad,
   input  wire logic clockOut
);
   logic [7:0] highLen;
   logic [7:0] lowLen;
   logic [7:0] bitCnt;
   logic       clkPrev;
   logic       enPrev;
   logic       seenEn;

   ////////////////////////////////////////////////////////////////////////////
   // The low width saturates so a long idle low never wraps to a small value
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         highLen <= 8'h00;
         lowLen  <= 8'h00;
      end else begin
         highLen <= clockOut ? highLen + 8'h01 : 8'h00;
         lowLen  <= clockOut ? 8'h00 : (lowLen == 8'hFF ? lowLen : lowLen + 8'h01);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bitCnt  <= 8'h00;
         clkPrev <= 1'b0;
         enPrev  <= 1'b1;
         seenEn  <= 1'b0;
      end else begin
         clkPrev <= serClk;
         enPrev  <= serEnN;
         seenEn  <= seenEn | (serEnN & ~enPrev);
         bitCnt  <= serEnN ? 8'h00 : bitCnt + {7'h00, serClk & ~clkPrev};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   idle_clk_low_a:   assert property (serEnN |-> !serClk) else $error("serial clock high outside frame");
   data_stable_a:    assert property (serClk |-> $stable(serData)) else $error("serial data moved with clock high");
   clk_high_len_a:   assert property ($rose(serClk) |-> serClk [*4] ##1 !serClk)
      else $error("serial clock high half wrong");
   clk_low_len_a:    assert property ($fell(serClk) |-> !serClk [*4]) else $error("serial clock low half short");
   word_whole_a:     assert property ($rose(serEnN) |-> bitCnt % 13 == 0 && bitCnt != 0)
      else $error("frame closed on a partial word");
   end_gap_a:        assert property ($rose(serEnN) |-> serEnN [*4]) else $error("enable high gap short");
   start_clk_a:      assert property ($rose(rstn) |-> ##[1:40] clockOut) else $error("no clock after reset");
   powerup_div_a:    assert property ($fell(clockOut) && !seenEn |-> highLen == 8'h10)
      else $error("power-up clock not lowest rate");
   div_legal_a:      assert property ($fell(clockOut) |-> highLen inside {8'h02, 8'h04, 8'h08, 8'h10})
      else $error("clock high width not a divider ratio");
   no_runt_a:        assert property ($rose(clockOut) |-> lowLen >= 8'h02) else $error("runt low pulse");
endmodule

// File: sim/tb.sv
// Testbench: APB controller driving the device end over the serial link.
// Assumes the package constants and a 250 MHz clock; SCLK_HALF set to 4.
`timescale 1ns/1ps
module tb;
   import rco_pkg::*;
   logic        clk     = 1'b0;
   logic        rstn    = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        extOscSel, overtoneMode, sleepMode, cfgSet, powerUpClk;
   logic [3:0]  oscResistor;
   logic [1:0]  runMode;
   logic [31:0] rd;
   logic        err;
   int          n;
   int          miscompares = 0;
   int          cmp_count   = 0;

   rco_link_if rco_link_if_i ();
   rco_dev_end rco_dev_end_i (.clk(clk), .rstn(rstn), .link(rco_link_if_i), .extOscSel(extOscSel),
      .oscResistor(oscResistor), .overtoneMode(overtoneMode), .sleepMode(sleepMode), .cfgSet(cfgSet),
      .runMode(runMode), .powerUpClk(powerUpClk));
   rco_host_end #(.SCLK_HALF(4)) rco_host_end_i (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(rco_link_if_i));
   rco_properties rco_properties_i (.clk(clk), .rstn(rstn), .serClk(rco_link_if_i.serClk),
      .serData(rco_link_if_i.serData), .serEnN(rco_link_if_i.serEnN),
      .cfgSwitchPad(rco_link_if_i.cfgSwitchPad), .clockOut(rco_link_if_i.clockOut));

   always #2 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [31:0] devSt();
      return {21'h0, powerUpClk, sleepMode, extOscSel, overtoneMode, cfgSet, runMode, oscResistor};
   endfunction

   // Entered just after a rising edge; pready is waited for, never assumed
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // One idle edge, so back-to-back calls never assign a strobe twice in a step
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic expErr);
      apb(1'b1, a, d);
      check("pslverr", {31'h0, expErr}, {31'h0, err});
   endtask

   task automatic send(input logic [4:0] a, input logic [7:0] d, input logic hold);
      wr(OFS_CMD, {15'h0, hold, 3'h0, a, d}, 1'b0);
      // A second command while shifting is refused and leaves the first in place
      wr(OFS_CMD, 32'h0000_1FFF, 1'b1);
      apb(1'b0, OFS_CMD, 32'h0);
      check("last command", {15'h0, hold, 3'h0, a, d}, rd);
      repeat (2) @(posedge clk);
      for (int i = 0; i < 300; i++) begin
         apb(1'b0, OFS_STAT, 32'h0);
         if (rd[STAT_BUSY] === 1'b0) break;
      end
      check("frame open", {31'h0, hold}, {31'h0, rd[STAT_OPEN]});
      // Commit lands a few cycles after the enable rises
      repeat (12) @(posedge clk);
   endtask

   task automatic hiLen();
      n = 0;
      for (int i = 0; i < 100 && rco_link_if_i.clockOut !== 1'b0; i++) @(posedge clk);
      for (int i = 0; i < 100 && rco_link_if_i.clockOut !== 1'b1; i++) @(posedge clk);
      while (rco_link_if_i.clockOut === 1'b1 && n < 100) begin
         n++;
         @(posedge clk);
      end
   endtask

   task automatic staysLow();
      logic bad;
      bad = 1'b0;
      // Run state only changes at the divider wrap, up to 32 cycles late
      repeat (40) @(posedge clk);
      repeat (80) begin
         @(posedge clk);
         if (rco_link_if_i.clockOut !== 1'b0) bad = 1'b1;
      end
      check("clockOut static low", 32'h0, {31'h0, bad});
      apb(1'b0, OFS_STAT, 32'h0);
      check("synced clock level", 32'h0, {31'h0, rd[STAT_CLK]});
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      check("reset state", 32'h600, devSt());
      hiLen();
      check("power-up high width", 32'd16, n);
      $display("test reset finished");

      apb(1'b0, OFS_PAD, 32'h0);
      check("pad reset", 32'h0, rd);
      wr(OFS_PAD, 32'h1, 1'b0);
      repeat (8) @(posedge clk);
      check("pad selects set 2", 32'h640, devSt());
      wr(OFS_PAD, 32'h0, 1'b0);
      apb(1'b0, 8'h0C, 32'h0);
      check("unmapped read", 32'h1, {31'h0, err} | rd);
      wr(OFS_STAT, 32'h1, 1'b1);
      $display("test registers finished");

      send(AD_CLK, 8'h35, 1'b1);
      check("no change before commit", 32'h600, devSt());
      send(5'h09, 8'h00, 1'b0);
      check("first commit, no realtime", 32'h285, devSt());
      staysLow();
      $display("test first sequence finished");

      for (int c = 0; c < 4; c++) begin
         send(AD_CLK, {2'b00, c[1:0], 4'h0}, 1'b1);
         send(RT_FIRST, 8'h83, 1'b0);
         repeat (40) @(posedge clk);
         hiLen();
         check("divided high width", 32'd16 >> c, n);
         check("running state", 32'h120, devSt());
      end
      $display("test dividers finished");

      send(RT_FIRST, 8'hB2, 1'b0);
      wr(OFS_PAD, 32'h1, 1'b0);
      repeat (40) @(posedge clk);
      check("set 2 via pad", 32'h070, devSt());
      hiLen();
      check("set 2 clock width", 32'd2, n);
      send(RT_FIRST, 8'hB6, 1'b0);
      check("pad and serial cancel", 32'h020, devSt());
      wr(OFS_PAD, 32'h0, 1'b0);
      repeat (8) @(posedge clk);
      check("set 2 via serial", 32'h070, devSt());
      send(RT_FIRST, 8'h02, 1'b0);
      check("sleep state", 32'h200, devSt());
      staysLow();
      send(RT_FIRST, 8'h80, 1'b0);
      staysLow();
      $display("test modes finished");
      conclude();
   end

   initial begin
      #200000;
      miscompares++;
      $display("watchdog expired");
      conclude();
   end
endmodule
